//--- hdl/trig_trace_ctrl.v
// trigger and trace control of an emulator: events, trace capture, breaks
// Notes on behaviour
// - with filtering on, trace writes are gated by the trigger event condition.
// - break-on-overflow set: halt once the trace buffer is completely full.
// - break-on-input set: rising input edge halts after the current instruction.
// - trigger output uses either range (start/stop) mode or single-address hit mode.
// - an access to the start address makes the range event active.
// - an access to the stop address ends the active range event.
// - hit mode: event high only in the cycle after each access to the selected address.
// - input and probe bits valid in trace only above address 2000H, else unknown.
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "trig_trace_regs.vh"
module trig_trace_ctrl #(
  parameter ADDR_W = 16,
  parameter DATA_W = 8,
  parameter DEPTH_LOG2 = 8
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // watched processor bus
  input wire bus_cycle,
  input wire [ADDR_W-1:0] bus_addr,
  input wire [DATA_W-1:0] bus_data,
  input wire instr_end,
  // external equipment
  input wire external_break_input,
  input wire [2:0] probe_in,
  output reg event_trigger_output,
  output reg halt_request,
  output reg irq
);
  localparam DEPTH = 1 << DEPTH_LOG2;
  localparam ENTRY_W = ADDR_W + DATA_W + 5;

  // ==========================================
  // configuration registers
  reg filter_en;
  reg hit_mode;
  reg brk_ovf;
  reg brk_ext;
  reg [ADDR_W-1:0] start_addr;
  reg [ADDR_W-1:0] stop_addr;
  reg [ADDR_W-1:0] hit_addr;
  reg [`ST_WIDTH-1:0] status;
  reg [`ST_WIDTH-1:0] irq_mask;
  reg [DEPTH_LOG2-1:0] rd_index;

  // ==========================================
  // hardware event
  reg range_active;
  wire range_start_event = bus_cycle && (bus_addr == start_addr);
  wire range_stop_event = bus_cycle && (bus_addr == stop_addr);
  wire single_address_hit_event = bus_cycle && (bus_addr == hit_addr);
  wire range_now = (range_active || range_start_event) && !range_stop_event;
  // range window includes start cycle and stop cycle
  wire range_cond = range_active || range_start_event;
  wire event_cond = hit_mode ? single_address_hit_event : range_cond;

  always @(posedge aclk) begin
    if (!aresetn) begin
      range_active <= 1'b0;
      event_trigger_output <= 1'b0;
    end else begin
      if (!hit_mode && bus_cycle)
        range_active <= range_now;
      else if (hit_mode)
        range_active <= 1'b0;
      event_trigger_output <= event_cond;
    end
  end

  // ==========================================
  // trace buffer
  reg [ENTRY_W-1:0] trace_mem [0:DEPTH-1];
  reg [DEPTH_LOG2:0] trace_count;
  wire trace_full = trace_count[DEPTH_LOG2];
  wire probe_ok = bus_addr > `PROBE_VALID_ADDR;
  // valid flag marks input/probe columns as known
  wire [4:0] probe_field = probe_ok ? {1'b1, external_break_input, probe_in} : 5'h00;
  wire trace_we = bus_cycle && !trace_full && (!filter_en || event_cond);
  reg [ENTRY_W-1:0] rd_entry;

  always @(posedge aclk) begin
    if (trace_we)
      trace_mem[trace_count[DEPTH_LOG2-1:0]] <= {probe_field, bus_addr, bus_data};
    rd_entry <= trace_mem[rd_index];
  end

  // ==========================================
  // breaks
  reg ext_prev;
  reg brk_pending;
  wire ext_rise = external_break_input && !ext_prev;
  wire ovf_set = trace_we && (trace_count == DEPTH - 1);

  // ==========================================
  // axi4-lite write path
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  wire [7:0] wa = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire have_aw = aw_held || (s_axi_awvalid && s_axi_awready);
  wire have_w = w_held || (s_axi_wvalid && s_axi_wready);
  wire do_write = have_aw && have_w && !s_axi_bvalid;
  wire wr_ctrl = do_write && wa == `REG_CTRL && s_axi_wstrb[0];
  wire wr_status = do_write && wa == `REG_STATUS && s_axi_wstrb[0];
  wire [`ST_WIDTH-1:0] ev_set = {halt_request == 1'b0 &&
    ((brk_pending && instr_end) || (brk_ovf && ovf_set)), ext_rise, ovf_set};
  wire [`ST_WIDTH-1:0] clr = wr_status ? wd[`ST_WIDTH-1:0] : {`ST_WIDTH{1'b0}};

  // ==========================================
  // sticky status bits, set wins over write-one-to-clear
  wire [`ST_WIDTH-1:0] next_status;
  genvar gi;
  generate
    for (gi = 0; gi < `ST_WIDTH; gi = gi + 1) begin : g_status
      assign next_status[gi] = ev_set[gi] | (status[gi] & ~clr[gi]);
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      filter_en <= 1'b0;
      hit_mode <= 1'b0;
      brk_ovf <= 1'b0;
      brk_ext <= 1'b0;
      start_addr <= {ADDR_W{1'b0}};
      stop_addr <= {ADDR_W{1'b0}};
      hit_addr <= {ADDR_W{1'b0}};
      irq_mask <= {`ST_WIDTH{1'b0}};
      rd_index <= {DEPTH_LOG2{1'b0}};
    end else begin
      // readies stay low from capture until the response is taken
      if (s_axi_awvalid && s_axi_awready && !do_write) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready && !do_write) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wa <= `REG_TRACE_RDDATA) ? `AXI_OKAY : `AXI_DECERR;
        if (wr_ctrl) begin
          filter_en <= wd[`CTRL_FILTER_EN];
          hit_mode <= wd[`CTRL_HIT_MODE];
          brk_ovf <= wd[`CTRL_BRK_OVF];
          brk_ext <= wd[`CTRL_BRK_EXT];
        end
        if (wa == `REG_START_ADDR)
          start_addr <= wd[ADDR_W-1:0];
        if (wa == `REG_STOP_ADDR)
          stop_addr <= wd[ADDR_W-1:0];
        if (wa == `REG_HIT_ADDR)
          hit_addr <= wd[ADDR_W-1:0];
        if (wa == `REG_IRQ_MASK)
          irq_mask <= wd[`ST_WIDTH-1:0];
        if (wa == `REG_TRACE_RDADDR)
          rd_index <= wd[DEPTH_LOG2-1:0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========================================
  // status and interrupt
  always @(posedge aclk) begin
    if (!aresetn) begin
      status <= {`ST_WIDTH{1'b0}};
      irq <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      status <= next_status;
      irq <= |(next_status & irq_mask);
      ext_prev <= external_break_input;
    end
  end

  // ==========================================
  // trace fill count
  always @(posedge aclk) begin
    if (!aresetn)
      trace_count <= {(DEPTH_LOG2+1){1'b0}};
    else if (wr_ctrl && wd[`CTRL_CLEAR_TRACE])
      trace_count <= {(DEPTH_LOG2+1){1'b0}};
    else if (trace_we)
      trace_count <= trace_count + 1'b1;
  end

  // ==========================================
  // halt on overflow, or after current instruction on input edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      brk_pending <= 1'b0;
      halt_request <= 1'b0;
    end else begin
      // resume clears; a break event in the same cycle still wins
      if (wr_ctrl && wd[`CTRL_RESUME]) begin
        halt_request <= 1'b0;
        brk_pending <= 1'b0;
      end
      if (brk_pending && instr_end) begin
        halt_request <= 1'b1;
        brk_pending <= 1'b0;
      end
      if (brk_ext && ext_rise)
        brk_pending <= 1'b1;
      if (brk_ovf && ovf_set)
        halt_request <= 1'b1;
    end
  end

  // ==========================================
  // axi4-lite read path
  reg [31:0] rd_mux;
  always @* begin
    case (s_axi_araddr)
      `REG_CTRL: rd_mux = {28'h000_0000, brk_ext, brk_ovf, hit_mode, filter_en};
      `REG_START_ADDR: rd_mux = {{(32-ADDR_W){1'b0}}, start_addr};
      `REG_STOP_ADDR: rd_mux = {{(32-ADDR_W){1'b0}}, stop_addr};
      `REG_HIT_ADDR: rd_mux = {{(32-ADDR_W){1'b0}}, hit_addr};
      `REG_STATUS: rd_mux = {{(32-`ST_WIDTH){1'b0}}, status};
      `REG_IRQ_MASK: rd_mux = {{(32-`ST_WIDTH){1'b0}}, irq_mask};
      `REG_TRACE_COUNT: rd_mux = {{(31-DEPTH_LOG2){1'b0}}, trace_count};
      `REG_TRACE_RDADDR: rd_mux = {{(32-DEPTH_LOG2){1'b0}}, rd_index};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  reg rd_wait;
  reg rd_is_data;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AXI_OKAY;
      rd_wait <= 1'b0;
      rd_is_data <= 1'b0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rresp <= (s_axi_araddr <= `REG_TRACE_RDDATA) ? `AXI_OKAY : `AXI_DECERR;
        rd_is_data <= s_axi_araddr == `REG_TRACE_RDDATA;
        s_axi_rdata <= rd_mux;
        rd_wait <= 1'b1;
      end
      // one wait cycle so the trace entry read settles
      if (rd_wait) begin
        rd_wait <= 1'b0;
        s_axi_rvalid <= 1'b1;
        if (rd_is_data)
          s_axi_rdata <= {{(32-ENTRY_W){1'b0}}, rd_entry};
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

//--- hdl/trig_trace_regs.vh
// register offsets, field positions, response codes for trigger/trace control
`ifndef TRIG_TRACE_REGS_VH
`define TRIG_TRACE_REGS_VH
// ==========================================
// register byte offsets
`define REG_CTRL 8'h00
`define REG_START_ADDR 8'h04
`define REG_STOP_ADDR 8'h08
`define REG_HIT_ADDR 8'h0C
`define REG_STATUS 8'h10
`define REG_IRQ_MASK 8'h14
`define REG_TRACE_COUNT 8'h18
`define REG_TRACE_RDADDR 8'h1C
`define REG_TRACE_RDDATA 8'h20
// ==========================================
// control fields
`define CTRL_FILTER_EN 0
`define CTRL_HIT_MODE 1
`define CTRL_BRK_OVF 2
`define CTRL_BRK_EXT 3
`define CTRL_RESUME 4
`define CTRL_CLEAR_TRACE 5
// ==========================================
// status fields (sticky, write one to clear)
`define ST_OVERFLOW 0
`define ST_EXT_EDGE 1
`define ST_HALTED 2
`define ST_WIDTH 3
// ==========================================
// valid-probe address threshold
`define PROBE_VALID_ADDR 16'h2000
`define AXI_OKAY 2'b00
`define AXI_DECERR 2'b11
`endif

//--- verif/trig_trace_ctrl_asserts.sv
// checker for trigger events, break timing and bus answers
`timescale 1ns/1ps
module trig_trace_chk #(
  parameter ADDR_W = 16
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // register bus
  input wire [7:0] s_axi_awaddr,
  input wire [31:0] s_axi_wdata,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // watched bus and pins
  input wire bus_cycle,
  input wire [ADDR_W-1:0] bus_addr,
  input wire instr_end,
  input wire external_break_input,
  input wire event_trigger_output,
  input wire halt_request
);
  // ==========
  // shadow of the settings, judged only while no write is in flight
  reg [3:0] ctl;
  reg [ADDR_W-1:0] sa, pa, ha;
  wire hm = ctl[1] && !s_axi_bvalid;
  wire rm = !ctl[1] && !s_axi_bvalid;
  wire at_s = bus_cycle && bus_addr == sa;
  wire at_p = bus_cycle && bus_addr == pa;
  wire at_h = bus_cycle && bus_addr == ha;
  always @(posedge aclk)
    if (s_axi_awvalid && s_axi_awready && s_axi_wvalid)
      case (s_axi_awaddr)
        8'h00: ctl <= s_axi_wdata[3:0];
        8'h04: sa <= s_axi_wdata[ADDR_W-1:0];
        8'h08: pa <= s_axi_wdata[ADDR_W-1:0];
        8'h0c: ha <= s_axi_wdata[ADDR_W-1:0];
        default: ;
      endcase
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_ext;
    ctl[3] && $rose(external_break_input) ##[1:8] instr_end;
  endsequence
  property p_hit; hm && at_h |=> event_trigger_output; endproperty
  a_hit: assert property (p_hit) else $error("hit event missing");
  property p_nohit; hm && !at_h |=> !event_trigger_output; endproperty
  a_nohit: assert property (p_nohit) else $error("event outside hit");
  property p_start; rm && at_s |=> event_trigger_output; endproperty
  a_start: assert property (p_start) else $error("range did not start");
  property p_stop; rm && at_p ##1 rm && !at_s |=> !event_trigger_output; endproperty
  a_stop: assert property (p_stop) else $error("range did not stop");
  property p_hold; rm && event_trigger_output && !at_p && !$past(at_p) |=> event_trigger_output;
  endproperty
  a_hold: assert property (p_hold) else $error("range event dropped");
  property p_ext; s_ext |=> ##[0:1] halt_request; endproperty
  a_ext: assert property (p_ext) else $error("no halt after input edge");
  property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("late write answer");
  property p_rd; s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("late read answer");
endmodule
bind trig_trace_ctrl trig_trace_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

//--- verif/cpu_bus_model.sv
// emulated processor bus: one single-cycle instruction per access
`timescale 1ns/1ps
module cpu_bus_model (
  // clock and requests
  input wire aclk,
  input wire run,
  input wire [15:0] pc,
  input wire halt_request,
  // watched bus
  output reg bus_cycle = 1'b0,
  output reg [15:0] bus_addr = 16'h0000,
  output reg [7:0] bus_data = 8'h00,
  output reg instr_end = 1'b0
);
  // ==========
  // halted core stops fetching; idle lines toggle instead of holding
  wire go = run && !halt_request;
  always @(posedge aclk) begin
    bus_cycle <= go;
    instr_end <= go;
    bus_addr <= go ? pc : ~bus_addr;
    bus_data <= go ? (pc[7:0] ^ 8'h5a) : ~bus_data;
  end
endmodule

//--- verif/emulator_trigger_trace_control_tb_top.sv
// self-checking bench for trigger and trace control
`timescale 1ns/1ps
module emulator_trigger_trace_control_tb_top;
  reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, rv;
  reg run, external_break_input;
  reg [15:0] pc, a;
  reg [2:0] probe_in = 3'b101;
  wire [3:0] s_axi_wstrb = 4'hf;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire bus_cycle, instr_end, event_trigger_output, halt_request, irq;
  wire [15:0] bus_addr;
  wire [7:0] bus_data;
  integer n_mismatch = 0, checks_done = 0, cycles = 0;
  trig_trace_ctrl dut (.*);
  cpu_bus_model bus_m (.*);
  // ==========
  // shared tasks
  task final_report;
    begin
      if (n_mismatch == 0 && checks_done > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task wr(input [7:0] ad, input [31:0] d);
    begin
      @(posedge aclk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, 2'b00);
    end
  endtask
  task rd(input [7:0] ad);
    begin
      @(posedge aclk);
      s_axi_araddr <= ad;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      rv = s_axi_rdata;
      chk(s_axi_rresp, (ad > 8'h20) ? 2'b11 : 2'b00);
    end
  endtask
  task bus(input r, input [15:0] ad);
    begin
      @(posedge aclk);
      run <= r;
      pc <= ad;
    end
  endtask
  // ==========
  // scenarios
  task t_reset;
    begin
      chk({s_axi_awready, s_axi_wready, s_axi_arready, event_trigger_output, irq}, 5'h1c);
      rd(8'h24);
      chk(rv, 0);
    end
  endtask
  task t_range;
    begin
      wr(8'h04, 32'h0000_3000);
      wr(8'h08, 32'h0000_3003);
      wr(8'h00, 32'h0000_0001);
      for (a = 16'h2fff; a < 16'h3005; a = a + 16'h0001) bus(1'b1, a);
      bus(1'b0, 16'h0000);
      rd(8'h18);
      chk(rv, 4);
      wr(8'h1c, 0);
      rd(8'h20);
      chk(rv, 32'h1530_005a);
    end
  endtask
  task t_hit;
    begin
      wr(8'h0c, 32'h0000_1000);
      wr(8'h00, 32'h0000_0023);
      bus(1'b1, 16'h0fff);
      bus(1'b1, 16'h1000);
      bus(1'b1, 16'h1001);
      bus(1'b1, 16'h1000);
      bus(1'b0, 16'h0000);
      rd(8'h18);
      chk(rv, 2);
      rd(8'h20);
      chk(rv, 32'h0010_005a);
    end
  endtask
  task t_ovf;
    begin
      wr(8'h14, 32'h0000_0001);
      wr(8'h00, 32'h0000_0024);
      for (a = 16'h4000; a < 16'h4005; a = a + 16'h0001) bus(1'b1, a);
      bus(1'b0, 16'h0000);
      rd(8'h18);
      chk({rv, halt_request}, 10);
      for (a = 16'h4005; a < 16'h4100; a = a + 16'h0001) bus(1'b1, a);
      bus(1'b0, 16'h0000);
      rd(8'h10);
      chk({rv, halt_request, irq}, 23);
      wr(8'h10, 32'h0000_0007);
      wr(8'h00, 32'h0000_0010);
      rd(8'h10);
      chk({rv, halt_request, irq}, 0);
    end
  endtask
  task t_ext;
    begin
      wr(8'h14, 32'h0000_0002);
      wr(8'h00, 32'h0000_0008);
      external_break_input <= 1'b1;
      repeat (4) @(posedge aclk);
      chk(halt_request, 0);
      bus(1'b1, 16'h5000);
      bus(1'b0, 16'h0000);
      repeat (3) @(posedge aclk);
      chk({halt_request, irq}, 3);
    end
  endtask
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      n_mismatch = n_mismatch + 1;
      final_report;
    end
  end
  initial begin
    {aresetn, run, external_break_input, pc, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_range;
    t_hit;
    t_ovf;
    t_ext;
    final_report;
  end
endmodule
